// >>> design/bssp_pin_if.sv
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
module bssp_pin_if #(
	parameter int TX_DIV_HALF = bssp_pkg::TX_INT_HALF_CYC,
	parameter int FIFO_DEPTH = 32
)
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone register slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Receive side from the line receiver, asynchronous.
	input wire logic rx_recovered_clock_i,
	input wire logic rx_line_data_i,
	input wire logic rx_line_fsync_i,
	input wire logic rx_line_mfsync_i,
	// Transmit pins from the framer, asynchronous.
	input wire logic tx_serial_data_in_i,
	input wire logic tx_multipurpose_in_i,
	// Output pins.
	output logic rx_recovered_clock_out_o,
	output logic rx_serial_data_out_o,
	output logic rx_sync_out_pin_o,
	output logic tx_clock_out_o,
	output logic tx_sync_out_pin_o,
	// Transmit bits toward the transmitter.
	output bssp_pkg::bssp_txw_s tx_bits_o,
	output logic tx_bits_valid_o,
	input wire logic tx_bits_ready_i
);
	import bssp_pkg::*;

	if (TX_DIV_HALF < 1 || TX_DIV_HALF > 4096)
	begin : g_bad
		$error("bssp_pin_if: TX_DIV_HALF out of range");
	end

	logic [3:0] tx_clock_source_select;
	bssp_rxc_s rxc;
	bssp_txc_s txc;
	bssp_mode_s mode;
	logic tx_ovf;
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic rxc_s, rxd_s, rxfs_s, rxmf_s, tser_s, tin_s;
	logic rxc_d, txc_d;
	logic rx_upd;
	logic tx_clk_sel;
	logic tx_smp;
	logic [11:0] div_cnt;
	logic int_clk;
	logic [8:0] tpos;
	logic [4:0] tfrm;
	logic [8:0] next_tpos;
	logic [4:0] next_tfrm;
	logic tin_fs, tin_mf;
	logic tfirst, tmfirst;
	logic push;
	logic fifo_ready;
	logic wr_en;
	logic [31:0] next_rdata;

	// All pin inputs pass two flops; clock and data keep the same delay.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
		end
		else
		begin
			sync1 <= {rx_recovered_clock_i, rx_line_data_i, rx_line_fsync_i,
				rx_line_mfsync_i, tx_serial_data_in_i, tx_multipurpose_in_i};
			sync2 <= sync1;
		end
	end
	assign {rxc_s, rxd_s, rxfs_s, rxmf_s, tser_s, tin_s} = sync2;

	// Internal transmit clock from a divider of the system clock.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			div_cnt <= 12'h000;
			int_clk <= 1'b0;
		end
		else if (div_cnt == 12'(TX_DIV_HALF - 1))
		begin
			div_cnt <= 12'h000;
			int_clk <= !int_clk;
		end
		else
			div_cnt <= div_cnt + 12'h001;
	end

	// Transmit clock mux; the pin source makes the input a clock.
	always_comb
	begin
		if (tx_clock_source_select == TX_CLOCK_SOURCE_SELECT_TIN)
			tx_clk_sel = tin_s;
		else if (tx_clock_source_select == TX_CLOCK_SOURCE_SELECT_RXCLK)
			tx_clk_sel = rxc_s;
		else
			tx_clk_sel = int_clk;
	end

	// Edge finders on the already synchronised clock levels.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rxc_d <= 1'b0;
			txc_d <= 1'b0;
		end
		else
		begin
			rxc_d <= rxc_s;
			txc_d <= tx_clk_sel;
		end
	end
	// Invert clear: data updates on rising edges, samples on falling ones.
	assign rx_upd = rxc.rx_clock_invert ? (rxc_d && !rxc_s) : (rxc_s && !rxc_d);
	assign tx_smp = txc.tx_clock_invert ? (tx_clk_sel && !txc_d)
		: (txc_d && !tx_clk_sel);

	// Receive serial data; low when disabled or outside DS1/E1.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rx_serial_data_out_o <= 1'b0;
		else if (!rxc.rx_serial_enable || mode.receiver_mode_field[1])
			rx_serial_data_out_o <= 1'b0;
		else if (rx_upd)
			rx_serial_data_out_o <= rxd_s;
	end

	// Receive sync pin: a one-bit pulse, or a static level when disabled.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rx_sync_out_pin_o <= 1'b0;
		else if (!rxc.rx_sync_out_enable)
			rx_sync_out_pin_o <= rxc.rx_sync_out_invert;
		else if (rx_upd)
			rx_sync_out_pin_o <= rxc.rx_sync_out_select ? rxmf_s : rxfs_s;
	end

	// Receive clock pin and transmit clock pin.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_recovered_clock_out_o <= 1'b0;
			tx_clock_out_o <= 1'b0;
		end
		else
		begin
			rx_recovered_clock_out_o <= rxc.rx_clock_out_enable ? rxc_s : rxc.rx_clock_invert;
			tx_clock_out_o <= txc.tx_clock_out_enable ? tx_clk_sel : 1'b0;
		end
	end

	// Transmit framing; the input pin may realign when it is not the clock.
	always_comb
	begin
		tin_fs = (tx_clock_source_select != TX_CLOCK_SOURCE_SELECT_TIN) && (txc.tin_role == TIN_FS) && tin_s;
		tin_mf = (tx_clock_source_select != TX_CLOCK_SOURCE_SELECT_TIN) && (txc.tin_role == TIN_MF) && tin_s;
		next_tpos = (tpos == frame_bits(mode.transmitter_mode_field) - 9'h001) ? 9'h000
			: tpos + 9'h001;
		next_tfrm = tfrm;
		if (tin_fs || tin_mf)
			next_tpos = 9'h000;
		if (next_tpos == 9'h000)
			next_tfrm = (tfrm == mf_frames(mode.transmitter_mode_field) - 5'h01) ? 5'h00
				: tfrm + 5'h01;
		if (tin_mf)
			next_tfrm = 5'h00;
		tfirst = (next_tpos == 9'h000);
		tmfirst = tfirst && (next_tfrm == 5'h00);
	end

	// Counters start at the last DS1 bit so the first sample in DS1 mode opens a frame.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tpos <= DS1_FRAME_BITS - 9'h001;
			tfrm <= DS1_MF_FRAMES - 5'h01;
		end
		else if (tx_smp && !mode.transmitter_mode_field[1])
		begin
			tpos <= next_tpos;
			tfrm <= next_tfrm;
		end
	end

	// Transmit sync pin, pulsed for the first bit of a frame or multiframe.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tx_sync_out_pin_o <= 1'b0;
		else if (!txc.tx_sync_out_enable)
			tx_sync_out_pin_o <= 1'b0;
		else if (tx_smp)
			tx_sync_out_pin_o <= txc.tx_sync_out_select ? tmfirst : tfirst;
	end

	// Sampled transmit bits go through the FIFO; other modes ignore the pin.
	assign push = tx_smp && !mode.transmitter_mode_field[1];

	bssp_fifo #(
		.WIDTH($bits(bssp_txw_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_data_i({tmfirst, tfirst, tser_s}),
		.in_valid_i(push),
		.in_ready_o(fifo_ready),
		.out_data_o(tx_bits_o),
		.out_valid_o(tx_bits_valid_o),
		.out_ready_i(tx_bits_ready_i)
	);

	// A pin cannot be stalled, so a full FIFO drops the bit and flags it.
	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tx_ovf <= 1'b0;
		else if (push && !fifo_ready)
			tx_ovf <= 1'b1;
		else if (wr_en && wb_adr_i == ADDR_STATUS && wb_dat_i[ST_OVF_POS])
			tx_ovf <= 1'b0;
	end

	// Control registers; writes land on the edge that sees ack high.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_clock_source_select <= TX_CLOCK_SOURCE_SELECT_RST;
			rxc <= RXC_RST;
			txc <= TXC_RST;
			mode <= MODE_RST;
		end
		else if (wr_en)
		begin
			case (wb_adr_i)
				ADDR_CLK_A: tx_clock_source_select <= wb_dat_i[3:0];
				ADDR_CLK_C: rxc <= wb_dat_i[5:0];
				ADDR_CLK_D: txc <= wb_dat_i[5:0];
				ADDR_MODE: mode <= wb_dat_i[3:0];
				default: ;
			endcase
		end
	end

	// Read mux; unmapped addresses read as zero.
	always_comb
	begin
		next_rdata = 32'h00000000;
		case (wb_adr_i)
			ADDR_CLK_A: next_rdata[3:0] = tx_clock_source_select;
			ADDR_CLK_C: next_rdata[5:0] = rxc;
			ADDR_CLK_D: next_rdata[5:0] = txc;
			ADDR_MODE: next_rdata[3:0] = mode;
			ADDR_STATUS:
			begin
				next_rdata[ST_OVF_POS] = tx_ovf;
				next_rdata[ST_VALID_POS] = tx_bits_valid_o;
				next_rdata[ST_READY_POS] = fifo_ready;
			end
			default: ;
		endcase
	end

	// One wait state: ack rises a cycle after the strobe and falls after one.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= next_rdata;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence rx_edge_seq;
		rx_upd;
	endsequence
	sequence tx_edge_seq;
		tx_smp && !mode.transmitter_mode_field[1];
	endsequence

	rsync_enable_a: assert property (
		rxc.rx_sync_out_enable && $past(rxc.rx_sync_out_enable) && $changed(rx_sync_out_pin_o)
		|-> $past(rx_upd))
		else $error("receive sync pin moved off an update edge");
	rsync_source_a: assert property (
		(rxc.rx_sync_out_enable and rx_edge_seq) ##1 rxc.rx_sync_out_enable
		|-> rx_sync_out_pin_o == ($past(rxc.rx_sync_out_select) ? $past(rxmf_s)
			: $past(rxfs_s)))
		else $error("receive sync pin carries the wrong source");
	rsync_gpo_a: assert property (
		!rxc.rx_sync_out_enable [*2] |-> rx_sync_out_pin_o == $past(rxc.rx_sync_out_invert))
		else $error("disabled receive sync pin ignores invert bit");
	rser_data_a: assert property (
		((rxc.rx_serial_enable && !mode.receiver_mode_field[1]) and rx_edge_seq) ##1
		(rxc.rx_serial_enable && !mode.receiver_mode_field[1]) |-> rx_serial_data_out_o == $past(rxd_s))
		else $error("receive data not presented");
	rser_edge_a: assert property (
		$rose(rx_serial_data_out_o) |-> $past(rx_upd))
		else $error("receive data rose off the selected edge");
	rser_off_a: assert property (
		!rxc.rx_serial_enable |=> !rx_serial_data_out_o)
		else $error("disabled receive data not low");
	rser_mode_a: assert property (
		mode.receiver_mode_field[1] |=> !rx_serial_data_out_o [*1])
		else $error("receive data active outside DS1 and E1");
	tclk_pin_a: assert property (
		!txc.tx_clock_out_enable ##1 !txc.tx_clock_out_enable |-> !tx_clock_out_o)
		else $error("disabled transmit clock pin toggles");
	tx_sample_a: assert property (
		(tx_edge_seq and fifo_ready) |->
		##2 tx_bits_valid_o)
		else $error("sampled bit did not reach the FIFO");
	tsync_enable_a: assert property (
		!txc.tx_sync_out_enable |=> !tx_sync_out_pin_o)
		else $error("disabled transmit sync pin driven");
	tsync_source_a: assert property (
		txc.tx_sync_out_enable && txc.tx_sync_out_select && tx_smp ##1 txc.tx_sync_out_enable
		|-> tx_sync_out_pin_o == $past(tmfirst))
		else $error("transmit sync pin carries the wrong source");
	tclk_source_a: assert property (
		txc.tx_clock_out_enable && tx_clock_source_select == TX_CLOCK_SOURCE_SELECT_TIN |=> tx_clock_out_o == $past(tin_s))
		else $error("transmit clock not taken from the input pin");
	tin_realign_a: assert property (
		(tx_edge_seq and tin_mf) |=> tpos == 9'h000 && tfrm == 5'h00)
		else $error("input multiframe sync did not realign");
	rclk_pin_a: assert property (
		!rxc.rx_clock_out_enable |=> rx_recovered_clock_out_o == $past(rxc.rx_clock_invert))
		else $error("disabled receive clock pin ignores invert bit");
	tser_mode_a: assert property (
		mode.transmitter_mode_field[1] |-> !push)
		else $error("transmit data taken outside DS1 and E1");
	rsync_pulse_a: assert property (
		$rose(rx_sync_out_pin_o) && rxc.rx_sync_out_enable |-> $past(rx_upd))
		else $error("receive sync pulse not aligned to a bit");
endmodule // bssp_pin_if

// >>> inc/bssp_pkg.sv
// Functional notes
// - Receive sync pin driven only when enabled.
// - Receive sync source: frame or multiframe sync.
// - Disabled receive sync pin follows invert bit.
// - DS1/E1 receive modes present NRZ serial data.
// - Serial data updates on selected receive edge.
// - Receive serial enable turns data output on.
// - Other receive modes hold serial data low.
// - Transmit clock pin shows mux clock when enabled.
// - Transmit data sampled on selected clock edge.
// - Transmit sync pin driven only when enabled.
// - Transmit sync source: frame or multiframe sync.
// - Source select zero takes clock from input pin.
// - Multipurpose input may realign frame or multiframe.
// - Receive clock pin: clock or invert level.
// - Transmit data taken only in DS1/E1 modes.
package bssp_pkg;
	// Register byte addresses.
	localparam logic [7:0] ADDR_CLK_A = 8'h00;
	localparam logic [7:0] ADDR_CLK_C = 8'h04;
	localparam logic [7:0] ADDR_CLK_D = 8'h08;
	localparam logic [7:0] ADDR_MODE = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	// Status register bit positions.
	localparam int ST_OVF_POS = 0;
	localparam int ST_VALID_POS = 1;
	localparam int ST_READY_POS = 2;
	// Mode encodings; the upper bit set means neither DS1 nor E1.
	localparam logic [1:0] MODE_DS1 = 2'h0;
	localparam logic [1:0] MODE_E1 = 2'h1;
	// Transmit clock source selections.
	localparam logic [3:0] TX_CLOCK_SOURCE_SELECT_TIN = 4'h0;
	localparam logic [3:0] TX_CLOCK_SOURCE_SELECT_RXCLK = 4'h1;
	// Multipurpose input sync roles.
	localparam logic [1:0] TIN_NONE = 2'h0;
	localparam logic [1:0] TIN_FS = 2'h1;
	localparam logic [1:0] TIN_MF = 2'h2;
	// Frame geometry.
	localparam logic [8:0] DS1_FRAME_BITS = 9'h0c1;
	localparam logic [8:0] E1_FRAME_BITS = 9'h100;
	localparam logic [4:0] DS1_MF_FRAMES = 5'h18;
	localparam logic [4:0] E1_MF_FRAMES = 5'h10;
	// Internal transmit clock half period.
	localparam int CLK_PERIOD_NS = 10;
	localparam int TX_INT_HALF_NS = 244;
	localparam int TX_INT_HALF_CYC = TX_INT_HALF_NS / CLK_PERIOD_NS;
	// Register layouts, least significant field last.
	typedef struct packed {
		logic rx_clock_out_enable;
		logic rx_serial_enable;
		logic rx_clock_invert;
		logic rx_sync_out_invert;
		logic rx_sync_out_select;
		logic rx_sync_out_enable;
	} bssp_rxc_s;
	typedef struct packed {
		logic [1:0] tin_role;
		logic tx_sync_out_select;
		logic tx_sync_out_enable;
		logic tx_clock_invert;
		logic tx_clock_out_enable;
	} bssp_txc_s;
	typedef struct packed {
		logic [1:0] transmitter_mode_field;
		logic [1:0] receiver_mode_field;
	} bssp_mode_s;
	// One transmit bit with its framing marks.
	typedef struct packed {
		logic mfsync;
		logic fsync;
		logic data;
	} bssp_txw_s;
	// Reset values.
	localparam logic [3:0] TX_CLOCK_SOURCE_SELECT_RST = 4'h0;
	localparam bssp_rxc_s RXC_RST = 6'h00;
	localparam bssp_txc_s TXC_RST = 6'h00;
	localparam bssp_mode_s MODE_RST = 4'h0;
	// Frame length in bits for a mode.
	function automatic logic [8:0] frame_bits(input logic [1:0] m);
		return (m == MODE_E1) ? E1_FRAME_BITS : DS1_FRAME_BITS;
	endfunction
	// Multiframe length in frames for a mode.
	function automatic logic [4:0] mf_frames(input logic [1:0] m);
		return (m == MODE_E1) ? E1_MF_FRAMES : DS1_MF_FRAMES;
	endfunction
endpackage

// >>> design/bssp_fifo.sv
`timescale 1ns/100ps
module bssp_fifo #(
	parameter int WIDTH = 3,
	parameter int DEPTH = 32
)
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Fill side.
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	// Drain side.
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	// Pointers wrap naturally, so only powers of two are served.
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
	begin : g_bad
		$error("bssp_fifo: DEPTH must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic load;

	// The output register refills whenever it is empty or being drained.
	assign push = in_valid_i && in_ready_o;
	assign load = (count != '0) && (!out_valid_o || out_ready_i);

	always_comb
	begin
		next_count = count;
		if (push && !load)
			next_count = count + 1'b1;
		else if (load && !push)
			next_count = count - 1'b1;
	end

	// Storage write port.
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end

	// Pointers, level and a registered ready so the pin-side stays clean.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_o <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (load)
				rd_ptr <= rd_ptr + 1'b1;
			count <= next_count;
			in_ready_o <= (next_count != DEPTH[AW:0]);
		end
	end

	// Registered read data.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			out_data_o <= '0;
			out_valid_o <= 1'b0;
		end
		else if (load)
		begin
			out_data_o <= mem[rd_ptr];
			out_valid_o <= 1'b1;
		end
		else if (out_ready_i)
			out_valid_o <= 1'b0;
	end
endmodule // bssp_fifo

// >>> dv/bssp_framer_model.sv
`timescale 1ns/100ps
module bssp_framer_model #(
	parameter int HALF_NS = 80,
	parameter int FRAME = 8
)
(
	// Run controls from the bench.
	input wire logic rx_run_i,
	input wire logic tx_run_i,
	// Receive line toward the device.
	output logic rx_clk_o,
	output logic rx_data_o,
	output logic rx_fsync_o,
	output logic rx_mfsync_o,
	// Transmit pins toward the device.
	output logic tx_clk_o,
	output logic tx_data_o
);
	int rx_idx;
	int tx_idx;
	// Receive bits change on the rising edge; the clock rests low between runs.
	initial
	begin
		rx_clk_o = 1'b0;
		rx_idx = 0;
		{rx_data_o, rx_fsync_o, rx_mfsync_o} = 3'h0;
		#3.3;
		forever
		begin
			wait (rx_run_i);
			#HALF_NS rx_clk_o = 1'b1;
			rx_data_o = rx_idx[0] ^ rx_idx[2] ^ rx_idx[3];
			rx_fsync_o = (rx_idx % FRAME) == 0;
			rx_mfsync_o = (rx_idx % (4 * FRAME)) == 0;
			rx_idx++;
			#HALF_NS rx_clk_o = 1'b0;
		end
	end
	// Data is launched on the rising edge so it is stable at the falling one.
	initial
	begin
		tx_clk_o = 1'b0;
		tx_idx = 0;
		tx_data_o = 1'b0;
		#7.1;
		forever
		begin
			wait (tx_run_i);
			#HALF_NS tx_clk_o = 1'b1;
			tx_data_o = tx_idx[0] ^ tx_idx[1] ^ tx_idx[4];
			tx_idx++;
			#HALF_NS tx_clk_o = 1'b0;
		end
	end
endmodule // bssp_framer_model

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb;
	import bssp_pkg::*;
	logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, cnt_clr;
	logic [7:0] wb_adr;
	logic [31:0] wb_wdat, wb_rdat;
	logic rx_go, tx_go, tx_ready, rx_clk, rx_data, rx_fs, rx_mf;
	logic tx_clk, tx_data, rclk_out, rser_out, rsync_out, tclk_out;
	logic tsync_out, tx_valid;
	logic [2:0] prev;
	bssp_txw_s tx_bits;
	int errors, checks, rises_rclk, rises_tclk, rises_tsync;
	logic tx_exp_q[$];
	// The system clock runs at 100 MHz.
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	bssp_framer_model model (.rx_run_i(rx_go), .tx_run_i(tx_go),
		.rx_clk_o(rx_clk), .rx_data_o(rx_data), .rx_fsync_o(rx_fs),
		.rx_mfsync_o(rx_mf), .tx_clk_o(tx_clk), .tx_data_o(tx_data));
	bssp_pin_if #(.TX_DIV_HALF(2), .FIFO_DEPTH(32)) dut (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .rx_recovered_clock_i(rx_clk),
		.rx_line_data_i(rx_data), .rx_line_fsync_i(rx_fs),
		.rx_line_mfsync_i(rx_mf), .tx_serial_data_in_i(tx_data),
		.tx_multipurpose_in_i(tx_clk), .rx_recovered_clock_out_o(rclk_out),
		.rx_serial_data_out_o(rser_out), .rx_sync_out_pin_o(rsync_out),
		.tx_clock_out_o(tclk_out), .tx_sync_out_pin_o(tsync_out),
		.tx_bits_o(tx_bits), .tx_bits_valid_o(tx_valid),
		.tx_bits_ready_i(tx_ready));
	// Rising edges on both clock pins and the transmit sync pin, seen by the system clock.
	always @(posedge clk_i)
	begin
		prev <= {rclk_out, tclk_out, tsync_out};
		if (cnt_clr)
		begin
			rises_rclk <= 0;
			rises_tclk <= 0;
			rises_tsync <= 0;
		end
		else
		begin
			if (rclk_out && !prev[2]) rises_rclk <= rises_rclk + 1;
			if (tclk_out && !prev[1]) rises_tclk <= rises_tclk + 1;
			if (tsync_out && !prev[0]) rises_tsync <= rises_tsync + 1;
		end
	end
	// Each transmit bit is recorded at the falling edge that samples it.
	always @(negedge tx_clk)
		tx_exp_q.push_back(tx_data);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Classic cycle: hold everything until ack is seen at a rising edge.
	task automatic wb_access(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_i);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} <= {2'h3, we, a, d};
		do @(posedge clk_i); while (wb_ack !== 1'b1);
		r = wb_rdat;
		{wb_cyc, wb_stb, wb_we} <= 3'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb_access(1'b1, a, d, r);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		wb_access(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask
	task automatic clr_counts;
		@(posedge clk_i);
		cnt_clr <= 1'b1;
		@(posedge clk_i);
		cnt_clr <= 1'b0;
	endtask
	// The check falls after the next rising edge, where only a falling
	// edge update still shows the old bit.
	task automatic rx_run(input int n, input logic d_on, input logic [1:0] sm);
		logic d, s;
		repeat (n)
		begin
			@(negedge rx_clk);
			d = d_on & rx_data;
			s = sm[1] ? sm[0] : (sm[0] ? rx_mf : rx_fs);
			@(posedge rx_clk);
			repeat (6) @(posedge clk_i);
			chk({31'h0, rser_out}, {31'h0, d});
			chk({31'h0, rsync_out}, {31'h0, s});
		end
	endtask
	task automatic t_regs;
		logic [7:0] adr[4] = '{ADDR_CLK_A, ADDR_CLK_C, ADDR_CLK_D, ADDR_MODE};
		logic [31:0] msk[4] = '{32'hf, 32'h3f, 32'h3f, 32'hf};
		rd_chk(ADDR_STATUS, 32'h4);
		foreach (adr[i])
		begin
			rd_chk(adr[i], 32'h0);
			wr(adr[i], 32'hffff_ffff);
			rd_chk(adr[i], msk[i]);
			wr(adr[i], 32'h0);
		end
		wr(8'h14, 32'hffff_ffff);
		rd_chk(8'h14, 32'h0);
		$display("Test registers done");
	endtask
	task automatic t_rx;
		wr(ADDR_CLK_C, 32'h19);
		rx_go <= 1'b1;
		rx_run(12, 1'b1, 2'h0);
		wr(ADDR_CLK_C, 32'h1b);
		rx_run(40, 1'b1, 2'h1);
		wr(ADDR_CLK_C, 32'h0c);
		rx_run(4, 1'b0, 2'h3);
		chk({31'h0, rclk_out}, 32'h1);
		wr(ADDR_CLK_C, 32'h18);
		wr(ADDR_MODE, 32'h2);
		rx_run(4, 1'b0, 2'h2);
		wr(ADDR_CLK_C, 32'h38);
		clr_counts;
		rx_run(8, 1'b0, 2'h2);
		chk({31'h0, rises_rclk >= 7}, 32'h1);
		rx_go <= 1'b0;
		$display("Test receive pins done");
	endtask
	// A mid-run reset puts the framing counters back on their last bit,
	// which earlier tests moved through the internal clock.
	task automatic do_reset;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic t_tx;
		int n;
		logic [2:0] e;
		do_reset;
		rd_chk(ADDR_CLK_C, 32'h0);
		wr(ADDR_MODE, 32'h0);
		wr(ADDR_CLK_D, 32'h05);
		clr_counts;
		tx_exp_q.delete();
		tx_go <= 1'b1;
		n = 0;
		while (n < 200)
		begin
			@(posedge clk_i);
			if (tx_valid === 1'b1)
			begin
				e = {n == 0, n % 193 == 0, tx_exp_q.pop_front()};
				chk({29'h0, tx_bits}, {29'h0, e});
				n++;
			end
		end
		tx_go <= 1'b0;
		repeat (100) @(posedge clk_i);
		chk({31'h0, rises_tclk >= 199}, 32'h1);
		chk(rises_tsync, 32'd2);
		tx_ready <= 1'b0;
		wr(ADDR_CLK_D, 32'h0);
		wr(ADDR_MODE, 32'h8);
		clr_counts;
		tx_go <= 1'b1;
		repeat (128) @(posedge clk_i);
		tx_go <= 1'b0;
		repeat (40) @(posedge clk_i);
		chk(rises_tclk, 32'd0);
		chk(rises_tsync, 32'd0);
		rd_chk(ADDR_STATUS, 32'h4);
		$display("Test transmit pins done");
	endtask
	// The consumer stalls while the framer keeps sending, then drains.
	task automatic t_fifo;
		wr(ADDR_MODE, 32'h0);
		wr(ADDR_CLK_D, 32'h01);
		tx_go <= 1'b1;
		repeat (640) @(posedge clk_i);
		tx_go <= 1'b0;
		repeat (40) @(posedge clk_i);
		rd_chk(ADDR_STATUS, 32'h3);
		tx_ready <= 1'b1;
		repeat (100) @(posedge clk_i);
		rd_chk(ADDR_STATUS, 32'h5);
		wr(ADDR_STATUS, 32'h1);
		rd_chk(ADDR_STATUS, 32'h4);
		tx_exp_q.delete();
		$display("Test buffer done");
	endtask
	// Internal clock with the input pin as multiframe sync: every high
	// phase of the pin realigns, so the sync pin pulses once per phase.
	// Then the recovered receive clock becomes the transmit clock.
	task automatic t_tin;
		wr(ADDR_CLK_D, 32'h2d);
		wr(ADDR_CLK_A, 32'h2);
		clr_counts;
		tx_go <= 1'b1;
		repeat (8) @(posedge tx_clk);
		tx_go <= 1'b0;
		repeat (40) @(posedge clk_i);
		chk(rises_tsync, 32'd8);
		wr(ADDR_CLK_A, 32'h1);
		clr_counts;
		rx_go <= 1'b1;
		repeat (8) @(posedge rx_clk);
		rx_go <= 1'b0;
		repeat (40) @(posedge clk_i);
		chk(rises_tclk, 32'd8);
		$display("Test input sync done");
	endtask
	task automatic final_report;
		$display("Checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// The tests need about 60 us, so a hang is cut well beyond that.
	initial
	begin
		#400000;
		errors++;
		final_report;
	end
	initial
	begin
		{rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = {4'h8, 40'h0};
		{rx_go, tx_go, tx_ready, cnt_clr} = 4'h3;
		errors = 0;
		checks = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs;
		t_rx;
		t_tx;
		t_fifo;
		t_tin;
		final_report;
	end
endmodule // tb
